//--- src/overlay_defs.vh
// Register offsets, field positions, reset values and encodings for the overlay control block.
// Assumes a word-addressed plain register port with byte offsets on 12 address bits.
// How it works
// - Window one asks early once FIFO level falls to its pre-threshold.
// - Window one raises request priority when level falls below threshold.
// - All FIFO depths and thresholds count levels of sixteen bytes.
// - Alpha depth-1 at 22:16 with threshold 30:24; window three low fields.
// - Alpha and window three issue early requests by own pre-thresholds.
// - Window one start offset: horizontal in 16-byte units, vertical in lines.
// - Icon goes to CRT when target bit clear, secondary display when set.
// - Additive mode blends icon plus graphics times one minus alpha.
// - True-colour icon alpha from constant or pixel top byte by select bit.
// - Icon format decodes 555, 565, RGB32, RGB10.
// - Constant alpha split in two nibbles, both reset to all ones.
// - Fading changes frame alpha by step each frame from constant alpha.
// - Fade selector set adds the step each frame.
// - Second display key shows video on match, or mismatch when inverted.
// - Second display key compare width follows the pixel mode.
// - Primary key has own enable and inverse with a 24-bit key.
// - Icon transparent and inverse colours compare 30, 24, 16 or 15 bits.
// - Windows show programmed pixel count plus one and line count.
// - Red equals A times Y plus B1 Cb plus C1 Cr plus D.
// - A is unsigned 1.4 fixed point.
// - B1 and C1 are sign-magnitude with two integer and three fraction bits.
// - D is eight-bit two's complement.
// - Separate enables for BT601 and BT709 coefficient sets.
`ifndef OVERLAY_DEFS_VH
`define OVERLAY_DEFS_VH
`define OFS_V1_FIFO 12'h258
`define OFS_V1_START 12'h25C
`define OFS_ICON_CTRL 12'h260
`define OFS_KEY2 12'h264
`define OFS_V3A_PRE 12'h268
`define OFS_V1_COUNT 12'h26C
`define OFS_ICON_TRANS 12'h270
`define OFS_ICON_INV 12'h274
`define OFS_V3A_FIFO 12'h278
`define OFS_V3_COUNT 12'h27C
`define OFS_KEY1 12'h280
`define OFS_CSC 12'h284
`define RST_ICON_CTRL 32'h000F00F0
`define RST_ZERO 32'h00000000
`define MASK_V1_FIFO 32'hFF00FFFF
`define MASK_START 32'h07FF07FF
`define MASK_ICON_CTRL 32'hFF0FFFF5
`define MASK_V3A_PRE 32'h007F00FF
`define MASK_COUNT 32'h0C000FFF
`define MASK_COLOUR 32'h3FFFFFFF
`define MASK_V3A_FIFO 32'h7F7FFFFF
`define MASK_KEY1 32'h60FFFFFF
`define MASK_CSC 32'hDF3F3FFF
`define LEVEL_BYTES 5'h10
`define FMT_555 2'h0
`define FMT_565 2'h1
`define FMT_RGB32 2'h2
`define FMT_RGB10 2'h3
`define GFX_8BPP 3'h0
`define GFX_555 3'h1
`define GFX_565 3'h2
`define GFX_RGB32 3'h3
`define GFX_RGB10 3'h4
`endif

//--- src/video_overlay_compose_ctrl.v
// Overlay compositing control: registers, fetch request levels, keying, icon alpha, red CSC.
// Assumes FIFO levels, pixels and frame strobe arrive on core_clk from fetch and display logic.
`timescale 1ns/1ps
`include "overlay_defs.vh"
module video_overlay_compose_ctrl (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Register port
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// FIFO occupancy in levels
	input wire [7:0] v1_fifo_level,
	input wire [7:0] v3_fifo_level,
	input wire [6:0] alpha_fifo_level,
	// Fetch requests
	output wire v1_req_early,
	output wire v1_req_high,
	output wire v3_req_early,
	output wire v3_req_high,
	output wire alpha_req_early,
	output wire alpha_req_high,
	// Window geometry
	output reg [14:0] v1_start_x_bytes,
	output reg [10:0] v1_start_y_lines,
	output reg [12:0] v1_width_pixels,
	output reg [1:0] v1_height_lines,
	output reg [12:0] v3_width_pixels,
	output reg [1:0] v3_height_lines,
	output reg [12:0] v1_fifo_bytes,
	output reg [12:0] v3_fifo_bytes,
	output reg [11:0] alpha_fifo_bytes,
	// Icon overlay
	input wire frame_start,
	input wire [31:0] icon_pixel,
	output reg icon_to_secondary,
	output reg icon_to_crt,
	output reg [7:0] icon_size,
	output reg [7:0] icon_alpha,
	output reg icon_additive,
	output reg icon_transparent,
	output reg icon_inverse,
	output reg [7:0] frame_alpha_value,
	// Colour keying
	input wire [2:0] gfx_mode,
	input wire [31:0] gfx2_pixel,
	input wire [23:0] gfx1_pixel,
	output reg show_video2,
	output reg show_video1,
	// Colour conversion
	input wire [7:0] luma,
	input wire [7:0] cb,
	input wire [7:0] cr,
	output reg [15:0] red_out,
	output reg csc_bt601,
	output reg csc_bt709
);
	reg [31:0] v1_fifo_ff, v1_start_ff, icon_ctrl_ff, key2_ff, v3a_pre_ff, v1_cnt_ff;
	reg [31:0] icon_trans_ff, icon_inv_ff, v3a_fifo_ff, v3_cnt_ff, key1_ff, csc_ff;
	reg [7:0] fade_ff;
	reg [8:0] nxt_fade;
	reg [31:0] rd_mux;
	reg [29:0] cmp_mask;
	reg [29:0] key2_mask;
	reg [23:0] key1_mask;
	reg key2_match, key1_match;
	wire [7:0] const_alpha;
	wire [29:0] key2_full;
	wire signed [9:0] a_term;
	wire signed [9:0] b_term;
	wire signed [9:0] c_term;
	wire signed [17:0] sum_r;

	// Register writes with per-register writable masks
	always @(posedge core_clk) begin
		if (rst) begin
			v1_fifo_ff <= `RST_ZERO;
			v1_start_ff <= `RST_ZERO;
			icon_ctrl_ff <= `RST_ICON_CTRL;
			key2_ff <= `RST_ZERO;
			v3a_pre_ff <= `RST_ZERO;
			v1_cnt_ff <= `RST_ZERO;
			icon_trans_ff <= `RST_ZERO;
			icon_inv_ff <= `RST_ZERO;
			v3a_fifo_ff <= `RST_ZERO;
			v3_cnt_ff <= `RST_ZERO;
			key1_ff <= `RST_ZERO;
			csc_ff <= `RST_ZERO;
		end else if (reg_wr) begin
			case (reg_addr)
				`OFS_V1_FIFO: v1_fifo_ff <= reg_wdata & `MASK_V1_FIFO;
				`OFS_V1_START: v1_start_ff <= reg_wdata & `MASK_START;
				`OFS_ICON_CTRL: icon_ctrl_ff <= reg_wdata & `MASK_ICON_CTRL;
				`OFS_KEY2: key2_ff <= reg_wdata;
				`OFS_V3A_PRE: v3a_pre_ff <= reg_wdata & `MASK_V3A_PRE;
				`OFS_V1_COUNT: v1_cnt_ff <= reg_wdata & `MASK_COUNT;
				`OFS_ICON_TRANS: icon_trans_ff <= reg_wdata & `MASK_COLOUR;
				`OFS_ICON_INV: icon_inv_ff <= reg_wdata & `MASK_COLOUR;
				`OFS_V3A_FIFO: v3a_fifo_ff <= reg_wdata & `MASK_V3A_FIFO;
				`OFS_V3_COUNT: v3_cnt_ff <= reg_wdata & `MASK_COUNT;
				`OFS_KEY1: key1_ff <= reg_wdata & `MASK_KEY1;
				`OFS_CSC: csc_ff <= reg_wdata & `MASK_CSC;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped reads return zero
	always @* begin
		case (reg_addr)
			`OFS_V1_FIFO: rd_mux = v1_fifo_ff;
			`OFS_V1_START: rd_mux = v1_start_ff;
			`OFS_ICON_CTRL: rd_mux = icon_ctrl_ff;
			`OFS_KEY2: rd_mux = key2_ff;
			`OFS_V3A_PRE: rd_mux = v3a_pre_ff;
			`OFS_V1_COUNT: rd_mux = v1_cnt_ff;
			`OFS_ICON_TRANS: rd_mux = icon_trans_ff;
			`OFS_ICON_INV: rd_mux = icon_inv_ff;
			`OFS_V3A_FIFO: rd_mux = v3a_fifo_ff;
			`OFS_V3_COUNT: rd_mux = v3_cnt_ff;
			`OFS_KEY1: rd_mux = key1_ff;
			`OFS_CSC: rd_mux = csc_ff;
			default: rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// Request levels: early at pre-threshold, high priority below threshold
	assign v1_req_early = v1_fifo_level <= v1_fifo_ff[31:24];
	assign v1_req_high = v1_fifo_level < v1_fifo_ff[15:8];
	assign v3_req_early = v3_fifo_level <= v3a_pre_ff[7:0];
	assign v3_req_high = v3_fifo_level < v3a_fifo_ff[15:8];
	assign alpha_req_early = alpha_fifo_level <= v3a_pre_ff[22:16];
	assign alpha_req_high = alpha_fifo_level < v3a_fifo_ff[30:24];

	// Fade alpha: whole byte steps by the four-bit step per frame, saturating
	assign const_alpha = {icon_ctrl_ff[7:4], icon_ctrl_ff[19:16]};
	always @* begin
		if (icon_ctrl_ff[9]) begin
			nxt_fade = {1'b0, fade_ff} + {5'h00, icon_ctrl_ff[15:12]};
			if (nxt_fade[8]) begin
				nxt_fade = 9'h0FF;
			end
		end else begin
			if (fade_ff < {4'h0, icon_ctrl_ff[15:12]}) begin
				nxt_fade = 9'h000;
			end else begin
				nxt_fade = {1'b0, fade_ff} - {5'h00, icon_ctrl_ff[15:12]};
			end
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			fade_ff <= 8'hFF;
		end else if (!icon_ctrl_ff[8]) begin
			fade_ff <= const_alpha;
		end else if (frame_start) begin
			fade_ff <= nxt_fade[7:0];
		end
	end

	// Icon colour compare width
	always @* begin
		case (icon_ctrl_ff[25:24])
			`FMT_555: cmp_mask = 30'h00007FFF;
			`FMT_565: cmp_mask = 30'h0000FFFF;
			`FMT_RGB32: cmp_mask = 30'h00FFFFFF;
			default: cmp_mask = 30'h3FFFFFFF;
		endcase
	end

	// Key compare widths per graphics mode
	assign key2_full = {key2_ff[31], key2_ff[28:0]};
	always @* begin
		case (gfx_mode)
			`GFX_8BPP: key2_mask = 30'h000000FF;
			`GFX_555: key2_mask = 30'h00007FFF;
			`GFX_565: key2_mask = 30'h0000FFFF;
			`GFX_RGB32: key2_mask = 30'h00FFFFFF;
			`GFX_RGB10: key2_mask = 30'h3FFFFFFF;
			default: key2_mask = 30'h00FFFFFF;
		endcase
		key1_mask = key2_mask[23:0];
		key2_match = ((gfx2_pixel[29:0] ^ key2_full) & key2_mask) == 30'h00000000;
		key1_match = ((gfx1_pixel ^ key1_ff[23:0]) & key1_mask) == 24'h000000;
	end

	// Red terms share three fraction bits; A drops its lowest fraction bit
	assign a_term = $signed({6'b000000, csc_ff[28:25]});
	assign b_term = csc_ff[21] ? -$signed({5'b00000, csc_ff[20:16]}) :
		$signed({5'b00000, csc_ff[20:16]});
	assign c_term = csc_ff[13] ? -$signed({5'b00000, csc_ff[12:8]}) :
		$signed({5'b00000, csc_ff[12:8]});
	assign sum_r = a_term * $signed({2'b00, luma}) + b_term * $signed({2'b00, cb}) +
		c_term * $signed({2'b00, cr}) + ($signed({{2{csc_ff[7]}}, csc_ff[7:0], 8'h00}) >>> 5);

	// Registered outputs
	always @(posedge core_clk) begin
		if (rst) begin
			v1_start_x_bytes <= 15'h0000;
			v1_start_y_lines <= 11'h000;
			v1_width_pixels <= 13'h0001;
			v1_height_lines <= 2'h0;
			v3_width_pixels <= 13'h0001;
			v3_height_lines <= 2'h0;
			v1_fifo_bytes <= 13'h0010;
			v3_fifo_bytes <= 13'h0010;
			alpha_fifo_bytes <= 12'h010;
			icon_to_secondary <= 1'b0;
			icon_to_crt <= 1'b0;
			icon_size <= 8'h20;
			icon_alpha <= 8'hFF;
			icon_additive <= 1'b0;
			icon_transparent <= 1'b0;
			icon_inverse <= 1'b0;
			frame_alpha_value <= 8'hFF;
			show_video2 <= 1'b0;
			show_video1 <= 1'b0;
			red_out <= 16'h0000;
			csc_bt601 <= 1'b0;
			csc_bt709 <= 1'b0;
		end else begin
			v1_start_x_bytes <= {v1_start_ff[26:16], 4'h0};
			v1_start_y_lines <= v1_start_ff[10:0];
			v1_width_pixels <= {1'b0, v1_cnt_ff[11:0]} + 13'h0001;
			v1_height_lines <= v1_cnt_ff[27:26];
			v3_width_pixels <= {1'b0, v3_cnt_ff[11:0]} + 13'h0001;
			v3_height_lines <= v3_cnt_ff[27:26];
			v1_fifo_bytes <= {1'b0, v1_fifo_ff[7:0], 4'h0} + {8'h00, `LEVEL_BYTES};
			v3_fifo_bytes <= {1'b0, v3a_fifo_ff[7:0], 4'h0} + {8'h00, `LEVEL_BYTES};
			alpha_fifo_bytes <= {1'b0, v3a_fifo_ff[22:16], 4'h0} + {7'h00, `LEVEL_BYTES};
			icon_to_secondary <= icon_ctrl_ff[0] & icon_ctrl_ff[31];
			icon_to_crt <= icon_ctrl_ff[0] & ~icon_ctrl_ff[31];
			case (icon_ctrl_ff[27:26])
				2'h0: icon_size <= 8'h20;
				2'h1: icon_size <= 8'h40;
				default: icon_size <= 8'h80;
			endcase
			if (icon_ctrl_ff[28] && icon_ctrl_ff[25]) begin
				icon_alpha <= icon_pixel[31:24];
			end else begin
				icon_alpha <= {fade_ff[7:4], 4'h0};
			end
			icon_additive <= icon_ctrl_ff[29];
			icon_transparent <= ((icon_pixel[29:0] ^ icon_trans_ff[29:0]) & cmp_mask) == 30'h0;
			icon_inverse <= ((icon_pixel[29:0] ^ icon_inv_ff[29:0]) & cmp_mask) == 30'h0;
			frame_alpha_value <= fade_ff;
			show_video2 <= key2_ff[30] & (key2_match ^ key2_ff[29]);
			show_video1 <= key1_ff[30] & (key1_match ^ key1_ff[29]);
			red_out <= sum_r[16:1];
			csc_bt601 <= csc_ff[31];
			csc_bt709 <= csc_ff[30];
		end
	end
endmodule

//--- tb/overlay_asserts.sv
// Port-level checks for the overlay control block.
// Assumes binding onto the design top, one clock, rst synchronous.
`timescale 1ns/1ps
`include "overlay_defs.vh"
module overlay_asserts (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Register port
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	// Watched ports
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire [14:0] v1_start_x_bytes,
	input wire [12:0] v1_fifo_bytes,
	input wire [12:0] v3_fifo_bytes,
	input wire [11:0] alpha_fifo_bytes,
	input wire icon_to_secondary,
	input wire icon_to_crt,
	input wire [7:0] icon_size,
	input wire [12:0] v1_width_pixels,
	input wire [12:0] v3_width_pixels,
	input wire frame_start,
	input wire v1_req_high
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (rst);
	rdata_idle_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("read data without a read");
	x_units_a: assert property (reg_wr && reg_addr == `OFS_V1_START |->
		##2 v1_start_x_bytes == {$past(reg_wdata[26:16], 2), 4'h0})
		else $error("start offset not in 16-byte units");
	v1_levels_a: assert property (reg_wr && reg_addr == `OFS_V1_FIFO |->
		##2 v1_fifo_bytes == {1'b0, $past(reg_wdata[7:0], 2), 4'h0} + 13'h0010)
		else $error("window one depth not in levels");
	v3_levels_a: assert property (reg_wr && reg_addr == `OFS_V3A_FIFO |->
		##2 v3_fifo_bytes == {1'b0, $past(reg_wdata[7:0], 2), 4'h0} + 13'h0010)
		else $error("window three depth not in levels");
	alpha_levels_a: assert property (reg_wr && reg_addr == `OFS_V3A_FIFO |->
		##2 alpha_fifo_bytes == {1'b0, $past(reg_wdata[22:16], 2), 4'h0} + 12'h010)
		else $error("alpha depth not in levels");
	icon_route_a: assert property (!(icon_to_secondary && icon_to_crt))
		else $error("icon sent to both displays");
	icon_size_a: assert property (reg_wr && reg_addr == `OFS_ICON_CTRL |->
		##2 icon_size == ($past(reg_wdata[27], 2) ? 8'h80 :
		($past(reg_wdata[26], 2) ? 8'h40 : 8'h20)))
		else $error("icon size does not follow its code");
	width_plus_a: assert property (v1_width_pixels != 13'h0 && v3_width_pixels != 13'h0)
		else $error("window width lost its plus one");
	v1_width_a: assert property (reg_wr && reg_addr == `OFS_V1_COUNT |->
		##2 v1_width_pixels == {1'b0, $past(reg_wdata[11:0], 2)} + 13'h0001)
		else $error("window one width not count plus one");
	cover property (reg_rd ##1 reg_rdata != 32'h0);
	cover property (frame_start);
	cover property (v1_req_high);
endmodule
bind video_overlay_compose_ctrl overlay_asserts chk_i (.*);

//--- tb/fetch_arbiter_model.sv
// Fetch side: FIFO filled by arbiter grants, drained by display.
// Assumes requests seen on core_clk; stall withholds grants.
`timescale 1ns/1ps
module fetch_arbiter_model #(parameter W = 8) (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Requests and stall
	input wire stall,
	input wire req_early,
	input wire req_high,
	// Occupancy in levels
	output reg [W-1:0] level
);
	always @(posedge core_clk) begin
		if (rst)
			level <= {{(W-5){1'b0}}, 5'h14};
		else if (req_early && !stall)
			level <= level + (req_high ? 2'h3 : 2'h2);
		else if (level != 0)
			level <= level - 1'b1;
	end
endmodule

//--- tb/video_overlay_compose_ctrl_test.sv
// Self-checking bench for the overlay control block.
// Assumes the design's offset macros and three fetch models.
`timescale 1ns/1ps
`include "overlay_defs.vh"
module video_overlay_compose_ctrl_test;
	reg core_clk = 1'b0;
	reg rst = 1'b1;
	reg [11:0] reg_addr = 12'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg frame_start = 1'b0;
	reg [31:0] icon_pixel = 32'h0;
	reg [2:0] gfx_mode = 3'h0;
	reg [31:0] gfx2_pixel = 32'h0;
	reg [23:0] gfx1_pixel = 24'h0;
	reg [7:0] luma = 8'h0, cb = 8'h0, cr = 8'h0;
	reg stall = 1'b0;
	wire [31:0] reg_rdata;
	wire [7:0] v1_fifo_level, v3_fifo_level, icon_size, icon_alpha, frame_alpha_value;
	wire [6:0] alpha_fifo_level;
	wire v1_req_early, v1_req_high, v3_req_early, v3_req_high, alpha_req_early, alpha_req_high;
	wire [14:0] v1_start_x_bytes;
	wire [10:0] v1_start_y_lines;
	wire [11:0] alpha_fifo_bytes;
	wire [12:0] v1_width_pixels, v3_width_pixels;
	wire [1:0] v1_height_lines, v3_height_lines;
	wire [12:0] v1_fifo_bytes, v3_fifo_bytes;
	wire icon_to_secondary, icon_to_crt, icon_additive, icon_transparent, icon_inverse;
	wire show_video2, show_video1, csc_bt601, csc_bt709;
	wire [15:0] red_out;
	integer miscompares = 0;
	integer cmp_count = 0;
	integer i;
	reg [31:0] rv;
	reg [43:0] ent;
	// Offset and writable mask of each register; the last entry is unmapped
	function [43:0] reg_of(input integer k);
		begin
			case (k)
				0: reg_of = {`OFS_V1_FIFO, `MASK_V1_FIFO};
				1: reg_of = {`OFS_V1_START, `MASK_START};
				2: reg_of = {`OFS_ICON_CTRL, `MASK_ICON_CTRL};
				3: reg_of = {`OFS_KEY2, 32'hFFFFFFFF};
				4: reg_of = {`OFS_V3A_PRE, `MASK_V3A_PRE};
				5: reg_of = {`OFS_V1_COUNT, `MASK_COUNT};
				6: reg_of = {`OFS_ICON_TRANS, `MASK_COLOUR};
				7: reg_of = {`OFS_ICON_INV, `MASK_COLOUR};
				8: reg_of = {`OFS_V3A_FIFO, `MASK_V3A_FIFO};
				9: reg_of = {`OFS_V3_COUNT, `MASK_COUNT};
				10: reg_of = {`OFS_KEY1, `MASK_KEY1};
				11: reg_of = {`OFS_CSC, `MASK_CSC};
				default: reg_of = {12'h290, 32'h00000000};
			endcase
		end
	endfunction
	video_overlay_compose_ctrl dut (.*);
	fetch_arbiter_model #(.W(8)) m1 (.core_clk, .rst, .stall, .req_early(v1_req_early),
		.req_high(v1_req_high), .level(v1_fifo_level));
	fetch_arbiter_model #(.W(8)) m3 (.core_clk, .rst, .stall, .req_early(v3_req_early),
		.req_high(v3_req_high), .level(v3_fifo_level));
	fetch_arbiter_model #(.W(7)) ma (.core_clk, .rst, .stall, .req_early(alpha_req_early),
		.req_high(alpha_req_high), .level(alpha_fifo_level));
	initial forever #10 core_clk = ~core_clk;
	task chk(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge core_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [11:0] a, output [31:0] d);
		begin
			@(posedge core_clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			@(negedge core_clk);
			d = reg_rdata;
		end
	endtask
	task regs_t;
		for (i = 0; i < 13; i = i + 1) begin
			ent = reg_of(i);
			rd(ent[43:32], rv);
			chk(rv, i == 2 ? `RST_ICON_CTRL : 32'h0);
			wr(ent[43:32], 32'hFFFFFFFF);
			rd(ent[43:32], rv);
			chk(rv, ent[31:0]);
		end
	endtask
	task fifo_t;
		begin
			wr(`OFS_V1_FIFO, 32'h0800041F);
			wr(`OFS_V3A_FIFO, 32'h0307050F);
			wr(`OFS_V3A_PRE, 32'h00060009);
			@(negedge core_clk);
			chk(v1_fifo_bytes, 32'h00000200);
			chk(v3_fifo_bytes, 32'h00000100);
			chk(alpha_fifo_bytes, 32'h00000080);
			for (i = 0; i < 70; i = i + 1) begin
				@(posedge core_clk);
				stall <= i < 30;
				@(negedge core_clk);
				chk({v1_req_early, v1_req_high}, {v1_fifo_level <= 8'h8, v1_fifo_level < 8'h4});
				chk({v3_req_early, v3_req_high}, {v3_fifo_level <= 8'h9, v3_fifo_level < 8'h5});
				chk({alpha_req_early, alpha_req_high},
					{alpha_fifo_level <= 7'h6, alpha_fifo_level < 7'h3});
			end
		end
	endtask
	task geom_t;
		begin
			wr(`OFS_V1_START, 32'h07FF0005);
			wr(`OFS_V1_COUNT, 32'h0C000FFF);
			wr(`OFS_V3_COUNT, 32'h04000000);
			repeat (3) @(negedge core_clk);
			chk({v1_start_x_bytes, v1_start_y_lines}, {15'h7FF0, 11'h5});
			chk({v1_width_pixels, v1_height_lines, v3_width_pixels, v3_height_lines},
				{13'h1000, 2'h3, 13'h1, 2'h1});
		end
	endtask
	task icon_t;
		begin
			@(posedge core_clk);
			icon_pixel <= 32'hA5123456;
			for (i = 0; i < 4; i = i + 1) begin
				wr(`OFS_ICON_CTRL, {i[0], 1'b0, i[1], 1'b1, i[1:0], i[1:0], 24'h030061});
				repeat (4) @(negedge core_clk);
				chk(icon_size, i == 0 ? 32'h20 : i == 1 ? 32'h40 : 32'h80);
				chk({icon_to_secondary, icon_to_crt, icon_additive}, {i[0], ~i[0], i[1]});
				chk(icon_alpha, i[1] ? 32'hA5 : 32'h60);
				chk(frame_alpha_value, 32'h63);
			end
			wr(`OFS_ICON_TRANS, 32'h00002345);
			wr(`OFS_ICON_INV, 32'h00FFA345);
			icon_pixel <= 32'hFFFFA345;
			for (i = 0; i < 4; i = i + 1) begin
				wr(`OFS_ICON_CTRL, {6'h0, i[1:0], 24'h000001});
				repeat (3) @(negedge core_clk);
				chk({icon_transparent, icon_inverse}, {i == 0, i < 3});
			end
		end
	endtask
	task frame(input [7:0] e);
		begin
			@(posedge core_clk);
			frame_start <= 1'b1;
			@(posedge core_clk);
			frame_start <= 1'b0;
			repeat (3) @(negedge core_clk);
			chk(frame_alpha_value, e);
		end
	endtask
	task fade_t;
		begin
			wr(`OFS_ICON_CTRL, 32'h000000E1);
			wr(`OFS_ICON_CTRL, 32'h0000F3E1);
			repeat (3) @(negedge core_clk);
			chk(frame_alpha_value, 32'hE0);
			for (i = 0; i < 3; i = i + 1)
				frame(i < 2 ? 8'hEF + 8'h0F * i : 8'hFF);
			wr(`OFS_ICON_CTRL, 32'h00000021);
			wr(`OFS_ICON_CTRL, 32'h00008121);
			for (i = 0; i < 5; i = i + 1)
				frame(i < 4 ? 8'h18 - 8'h08 * i : 8'h0);
		end
	endtask
	task key_row(input [31:0] k2, input [31:0] k1, input [2:0] m, input [31:0] p2,
		input [23:0] p1, input [1:0] e);
		begin
			wr(`OFS_KEY2, k2);
			wr(`OFS_KEY1, k1);
			gfx_mode <= m;
			gfx2_pixel <= p2;
			gfx1_pixel <= p1;
			repeat (3) @(negedge core_clk);
			chk({show_video2, show_video1}, e);
		end
	endtask
	task key_t;
		begin
			key_row(32'h40AB1234, 32'h40AB1234, `GFX_565, 32'h1234, 24'h1234, 2'h3);
			key_row(32'h60AB1234, 32'h60AB1234, `GFX_565, 32'h1234, 24'h1234, 2'h0);
			key_row(32'hC0001234, 32'h0, `GFX_RGB10, 32'h20001234, 24'h1234, 2'h2);
			key_row(32'hC0001234, 32'h0, `GFX_RGB10, 32'h00001234, 24'h1234, 2'h0);
			key_row(32'h4FFFFF34, 32'h40FFFF34, `GFX_8BPP, 32'h34, 24'h34, 2'h3);
			key_row(32'h40ABCDEF, 32'h60ABCDEF, `GFX_RGB32, 32'hFFABCDEF, 24'hABCDEE, 2'h3);
			key_row(32'h4000F234, 32'h4000F234, `GFX_555, 32'h7234, 24'h7234, 2'h3);
		end
	endtask
	task csc_t;
		begin
			@(posedge core_clk);
			luma <= 8'h64;
			cb <= 8'h10;
			cr <= 8'h20;
			wr(`OFS_CSC, 32'h900928F6);
			repeat (3) @(negedge core_clk);
			chk({csc_bt601, csc_bt709, red_out}, 18'h20130);
			wr(`OFS_CSC, 32'h40000000);
			repeat (3) @(negedge core_clk);
			chk({csc_bt601, csc_bt709, red_out}, 18'h10000);
		end
	endtask
	task conclude;
		begin
			$display("compares %0d mismatches %0d", cmp_count, miscompares);
			if (miscompares == 0 && cmp_count > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		regs_t;
		fifo_t;
		geom_t;
		icon_t;
		fade_t;
		key_t;
		csc_t;
		conclude;
	end
	initial begin
		#400000;
		miscompares = miscompares + 1;
		conclude;
	end
endmodule
